/* hw/adm_defines.svh */
`ifndef ADM_DEFINES_SVH
`define ADM_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets on the plain register port.
// ----------------------------------------------------------------------
`define ADM_OFS_FREQ 4'h0
`define ADM_OFS_GAIN 4'h1
`define ADM_OFS_TXPWR 4'h2
`define ADM_OFS_CONTRAST 4'h3
`define ADM_OFS_MCU_INT_CTRL 4'h4
`define ADM_OFS_DSP_STAT_CTRL 4'h5
`define ADM_OFS_MCU_STAT_CTRL 4'h6
`define ADM_OFS_SIG_STRENGTH 4'h7
`define ADM_OFS_BATTERY 4'h8

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define ADM_BIT_GAIN_EN 0
`define ADM_BIT_FREQ_EN 1
`define ADM_BIT_TX_EN 0
`define ADM_BIT_CONTRAST_PD 0
`define ADM_CONTRAST_MSB 7
`define ADM_CONTRAST_LSB 4
`define ADM_BIT_CONV_READY 0
`define ADM_BIT_ADC_POWER 1
`define ADM_FS_MSB 3
`define ADM_FS_LSB 2

// ----------------------------------------------------------------------
// Reset values and range codes.
// ----------------------------------------------------------------------
`define ADM_RST_CODE8 8'h00
`define ADM_RST_CODE4 4'h0
`define ADM_RST_FS 2'h0
`define ADM_FS_FORBIDDEN 2'h1

// ----------------------------------------------------------------------
// Timing: figures in ns, counts in cycles of the 40 MHz clock.
// ----------------------------------------------------------------------
`define ADM_CLK_PERIOD_NS 25
`define ADM_CONV_TIME_NS 20000
`define ADM_IDLE_TIME_NS 40000
`define ADM_CNT_W 11
`define ADM_CONV_CYC 11'((`ADM_CONV_TIME_NS + `ADM_CLK_PERIOD_NS - 1) / `ADM_CLK_PERIOD_NS)
`define ADM_IDLE_CYC 11'((`ADM_IDLE_TIME_NS + `ADM_CLK_PERIOD_NS - 1) / `ADM_CLK_PERIOD_NS)

`endif

/* hw/adm_pkg.sv */
package adm_pkg;

    // Register port request, one cycle per access.
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } adm_bus_req_t;

    // Eight-bit converter output: code and output enable.
    typedef struct packed {
        logic [7:0] code;
        logic oe;
    } adm_dac8_t;

    // Four-bit contrast converter output.
    typedef struct packed {
        logic [3:0] code;
        logic oe;
    } adm_dac4_t;

    // Monitor converter sequencing.
    typedef enum logic {
        ADM_ST_IDLE,
        ADM_ST_CONV
    } adm_adc_state_t;

endpackage

/* hw/adm_ctrl.sv */
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adm_defines.svh"

module adm_ctrl (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire adm_pkg::adm_bus_req_t bus_req,
    input wire logic [7:0] adc_sample,
    output var logic [7:0] rd_data,
    output var adm_pkg::adm_dac8_t freq_correction_dac,
    output var adm_pkg::adm_dac8_t gain_control_dac,
    output var adm_pkg::adm_dac8_t tx_power_dac,
    output var adm_pkg::adm_dac4_t contrast_dac,
    output var logic [1:0] aux_full_scale_sel,
    output var logic adc_power,
    output var logic adc_input_sel
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------

    logic wr_freq;
    logic wr_gain;
    logic wr_txpwr;
    logic wr_contrast;
    logic wr_int_ctrl;
    logic wr_dsp_ctrl;
    logic wr_mcu_ctrl;
    logic wr_sig;
    logic wr_bat;
    logic rd_result;
    logic start_conv;

    // Write strobes per register.
    assign wr_freq = bus_req.wr && bus_req.addr == `ADM_OFS_FREQ;
    assign wr_gain = bus_req.wr && bus_req.addr == `ADM_OFS_GAIN;
    assign wr_txpwr = bus_req.wr && bus_req.addr == `ADM_OFS_TXPWR;
    assign wr_contrast = bus_req.wr && bus_req.addr == `ADM_OFS_CONTRAST;
    assign wr_int_ctrl = bus_req.wr && bus_req.addr == `ADM_OFS_MCU_INT_CTRL;
    assign wr_dsp_ctrl = bus_req.wr && bus_req.addr == `ADM_OFS_DSP_STAT_CTRL;
    assign wr_mcu_ctrl = bus_req.wr && bus_req.addr == `ADM_OFS_MCU_STAT_CTRL;
    assign wr_sig = bus_req.wr && bus_req.addr == `ADM_OFS_SIG_STRENGTH;
    assign wr_bat = bus_req.wr && bus_req.addr == `ADM_OFS_BATTERY;

    // Either converter location starts a conversion; data is ignored.
    assign start_conv = wr_sig || wr_bat;

    // Reading either result location consumes the ready flag.
    assign rd_result = bus_req.rd
        && (bus_req.addr == `ADM_OFS_SIG_STRENGTH
        || bus_req.addr == `ADM_OFS_BATTERY);

    // ------------------------------------------------------------------
    // Auxiliary DAC registers
    // ------------------------------------------------------------------

    logic [7:0] freq_code_ff;
    logic [7:0] gain_code_ff;
    logic [7:0] tx_code_ff;
    logic [3:0] contrast_code_ff;
    logic contrast_en_ff;
    logic freq_en_ff;
    logic gain_en_ff;
    logic tx_en_ff;
    logic [1:0] full_scale_ff;

    // Eight-bit data registers load the full byte on a write.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            freq_code_ff <= `ADM_RST_CODE8;
            gain_code_ff <= `ADM_RST_CODE8;
            tx_code_ff <= `ADM_RST_CODE8;
        end else begin
            if (wr_freq) begin
                freq_code_ff <= bus_req.wdata;
            end
            if (wr_gain) begin
                gain_code_ff <= bus_req.wdata;
            end
            if (wr_txpwr) begin
                tx_code_ff <= bus_req.wdata;
            end
        end
    end

    // Contrast register: code in the upper nibble, power-down in bit 0.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            contrast_code_ff <= `ADM_RST_CODE4;
            contrast_en_ff <= 1'b0;
        end else if (wr_contrast) begin
            contrast_code_ff <=
                bus_req.wdata[`ADM_CONTRAST_MSB:`ADM_CONTRAST_LSB];
            contrast_en_ff <=
                !bus_req.wdata[`ADM_BIT_CONTRAST_PD];
        end
    end

    // Enable bits; the three RF converters start out disabled.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            freq_en_ff <= 1'b0;
            gain_en_ff <= 1'b0;
            tx_en_ff <= 1'b0;
        end else begin
            if (wr_int_ctrl) begin
                gain_en_ff <= bus_req.wdata[`ADM_BIT_GAIN_EN];
                freq_en_ff <= bus_req.wdata[`ADM_BIT_FREQ_EN];
            end
            if (wr_dsp_ctrl) begin
                tx_en_ff <= bus_req.wdata[`ADM_BIT_TX_EN];
            end
        end
    end

    logic [1:0] nxt_full_scale;

    // A forbidden range code is dropped so the old range stays in force.
    always_comb begin
        nxt_full_scale = full_scale_ff;
        if (wr_mcu_ctrl && bus_req.wdata[`ADM_FS_MSB:`ADM_FS_LSB]
            != `ADM_FS_FORBIDDEN) begin
            nxt_full_scale = bus_req.wdata[`ADM_FS_MSB:`ADM_FS_LSB];
        end
    end

    // Range field register.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            full_scale_ff <= `ADM_RST_FS;
        end else begin
            full_scale_ff <= nxt_full_scale;
        end
    end

    // Output enables low mean the pad is released to high impedance.
    assign freq_correction_dac = '{code: freq_code_ff,
                                   oe: freq_en_ff};
    assign gain_control_dac = '{code: gain_code_ff,
                                oe: gain_en_ff};
    assign tx_power_dac = '{code: tx_code_ff, oe: tx_en_ff};
    assign contrast_dac = '{code: contrast_code_ff,
                            oe: contrast_en_ff};
    assign aux_full_scale_sel = full_scale_ff;

    // ------------------------------------------------------------------
    // Monitor converter sequencing
    // ------------------------------------------------------------------

    adm_pkg::adm_adc_state_t state_ff;
    adm_pkg::adm_adc_state_t nxt_state;
    logic [`ADM_CNT_W-1:0] conv_cnt_ff;
    logic [`ADM_CNT_W-1:0] idle_cnt_ff;
    logic [7:0] result_ff;
    logic ready_ff;
    logic power_ff;
    logic sel_ff;
    logic conv_done;
    logic idle_timeout;

    assign conv_done = state_ff == adm_pkg::ADM_ST_CONV
        && conv_cnt_ff == `ADM_CONV_CYC - 11'h001 && !start_conv;
    assign idle_timeout = idle_cnt_ff == `ADM_IDLE_CYC;

    // Next state: a start always (re)enters the conversion.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            adm_pkg::ADM_ST_IDLE: begin
                if (start_conv) begin
                    nxt_state = adm_pkg::ADM_ST_CONV;
                end
            end
            adm_pkg::ADM_ST_CONV: begin
                if (conv_done) begin
                    nxt_state = adm_pkg::ADM_ST_IDLE;
                end
            end
            default: begin
                nxt_state = adm_pkg::ADM_ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= adm_pkg::ADM_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Conversion timer restarts on every start write.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            conv_cnt_ff <= '0;
        end else if (start_conv) begin
            conv_cnt_ff <= '0;
        end else if (state_ff == adm_pkg::ADM_ST_CONV) begin
            conv_cnt_ff <= conv_cnt_ff + 11'h001;
        end
    end

    // Idle timer counts cycles since the last request, saturating.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            idle_cnt_ff <= '0;
        end else if (start_conv) begin
            idle_cnt_ff <= '0;
        end else if (!idle_timeout) begin
            idle_cnt_ff <= idle_cnt_ff + 11'h001;
        end
    end

    // Power follows a request and drops at the latch or on idle timeout.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            power_ff <= 1'b0;
        end else if (start_conv) begin
            power_ff <= 1'b1;
        end else if (conv_done || idle_timeout) begin
            power_ff <= 1'b0;
        end
    end

    // Input select is taken from the location that was written.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sel_ff <= 1'b0;
        end else if (start_conv) begin
            sel_ff <= wr_bat;
        end
    end

    // Shared result holds its value while the converter is off.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            result_ff <= `ADM_RST_CODE8;
        end else if (conv_done) begin
            result_ff <= adc_sample;
        end
    end

    // Ready flag: completion wins over a same-cycle read.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ready_ff <= 1'b0;
        end else if (conv_done) begin
            ready_ff <= 1'b1;
        end else if (rd_result || start_conv) begin
            ready_ff <= 1'b0;
        end
    end

    assign adc_power = power_ff;
    assign adc_input_sel = sel_ff;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------

    logic [7:0] rd_data_ff;
    logic [7:0] nxt_rd_data;

    // Read mux; unmapped addresses and idle cycles return zero.
    always_comb begin
        nxt_rd_data = 8'h00;
        if (bus_req.rd) begin
            case (bus_req.addr)
                `ADM_OFS_FREQ: nxt_rd_data = freq_code_ff;
                `ADM_OFS_GAIN: nxt_rd_data = gain_code_ff;
                `ADM_OFS_TXPWR: nxt_rd_data = tx_code_ff;
                `ADM_OFS_CONTRAST: begin
                    nxt_rd_data = {contrast_code_ff, 3'h0, !contrast_en_ff};
                end
                `ADM_OFS_MCU_INT_CTRL: begin
                    nxt_rd_data = {6'h00, freq_en_ff, gain_en_ff};
                end
                `ADM_OFS_DSP_STAT_CTRL: nxt_rd_data = {7'h00, tx_en_ff};
                `ADM_OFS_MCU_STAT_CTRL: begin
                    nxt_rd_data = {4'h0, full_scale_ff, power_ff, ready_ff};
                end
                `ADM_OFS_SIG_STRENGTH: nxt_rd_data = result_ff;
                `ADM_OFS_BATTERY: nxt_rd_data = result_ff;
                default: nxt_rd_data = 8'h00;
            endcase
        end
    end

    // Read data register, valid only in the cycle after the strobe.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_ff <= 8'h00;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data = rd_data_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    logic [`ADM_CNT_W-1:0] since_start_ff;

    // Cycles since the last start write, for latency checks.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            since_start_ff <= '0;
        end else if (start_conv) begin
            since_start_ff <= 11'h000;
        end else if (since_start_ff != `ADM_IDLE_CYC) begin
            since_start_ff <= since_start_ff + 11'h001;
        end
    end

    a_freq_update: assert property (wr_freq |=>
        freq_correction_dac.code == $past(bus_req.wdata))
        else $error("Frequency DAC code did not follow the write.");

    a_gain_enable: assert property (wr_int_ctrl |=>
        gain_control_dac.oe == $past(bus_req.wdata[`ADM_BIT_GAIN_EN])
        && freq_correction_dac.oe == $past(bus_req.wdata[`ADM_BIT_FREQ_EN]))
        else $error("Gain or frequency DAC enable is wrong.");

    a_tx_enable: assert property (wr_dsp_ctrl |=>
        tx_power_dac.oe == $past(bus_req.wdata[`ADM_BIT_TX_EN]))
        else $error("Transmit DAC enable did not follow its bit.");

    a_contrast_load: assert property (wr_contrast |=>
        contrast_dac.code == $past(bus_req.wdata[7:4])
        && contrast_dac.oe != $past(bus_req.wdata[0]))
        else $error("Contrast DAC register loaded wrongly.");

    a_range_legal: assert property (
        aux_full_scale_sel != `ADM_FS_FORBIDDEN)
        else $error("Forbidden full-scale range is in force.");

    a_ready_latency: assert property ($rose(ready_ff) |->
        since_start_ff == `ADM_CONV_CYC)
        else $error("Ready flag rose at the wrong time.");

    a_ready_clear: assert property ((rd_result && !conv_done) |=>
        !ready_ff)
        else $error("Result read did not clear the ready flag.");

    a_restart_clear: assert property (start_conv |=>
        !ready_ff [*8])
        else $error("Ready flag set too soon after a start.");

    a_power_on: assert property (start_conv |=>
        adc_power && adc_input_sel == $past(wr_bat))
        else $error("Start write did not power the converter.");

    a_power_off: assert property ($fell(power_ff) |->
        $past(conv_done) || $past(idle_timeout))
        else $error("Converter powered down without cause.");

    a_result_held: assert property (!conv_done |=>
        $stable(result_ff))
        else $error("Result changed without a completed conversion.");

    c_conv_done: cover property (start_conv ##[1:900] $rose(ready_ff));
    c_restart: cover property (start_conv ##[1:200] start_conv);
    c_contrast_on: cover property ($rose(contrast_dac.oe));
    c_range_top: cover property (aux_full_scale_sel == 2'h3);

endmodule // adm_ctrl

`default_nettype wire

/* tb/adm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Processor side of the register port: one-cycle strobes, read data taken
// in the cycle after the read strobe.
module adm_host_model (
    input wire logic clk_sys,
    input wire logic [7:0] rd_data,
    output var adm_pkg::adm_bus_req_t bus_req
);

    // The port is quiet from time zero.
    initial begin
        bus_req = '0;
    end

    // One write cycle; the strobe is dropped at the edge that takes it.
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask

    // One read cycle; the answer is taken at the following edge.
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req <= '0;
        @(posedge clk_sys);
        v = rd_data;
    endtask

endmodule // adm_host_model

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adm_defines.svh"

`define CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
        err_total++; \
    end \
end

module tb_top;

    logic clk_sys;
    logic rst_b;
    logic [7:0] adc_sample;
    logic [7:0] rd_data;
    adm_pkg::adm_bus_req_t bus_req;
    adm_pkg::adm_dac8_t freq_correction_dac;
    adm_pkg::adm_dac8_t gain_control_dac;
    adm_pkg::adm_dac8_t tx_power_dac;
    adm_pkg::adm_dac4_t contrast_dac;
    logic [1:0] aux_full_scale_sel;
    logic adc_power;
    logic adc_input_sel;
    int err_total;
    int tests_run;
    int cycles;
    int n;
    logic [7:0] d;
    logic [1:0] fs_codes [3];

    adm_ctrl adm_ctrl_i (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .bus_req(bus_req),
        .adc_sample(adc_sample),
        .rd_data(rd_data),
        .freq_correction_dac(freq_correction_dac),
        .gain_control_dac(gain_control_dac),
        .tx_power_dac(tx_power_dac),
        .contrast_dac(contrast_dac),
        .aux_full_scale_sel(aux_full_scale_sel),
        .adc_power(adc_power),
        .adc_input_sel(adc_input_sel)
    );

    adm_host_model adm_host_model_i (
        .clk_sys(clk_sys),
        .rd_data(rd_data),
        .bus_req(bus_req)
    );

    // --------------------------------------------------------------
    // Clock, analog front end and watchdog.
    // --------------------------------------------------------------

    // The 40 MHz system clock.
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // The sampled input is only meaningful while powered; otherwise it
    // wanders so that a stale latch cannot pass by accident.
    always @(posedge clk_sys) begin
        if (adc_power === 1'b1) begin
            adc_sample <= adc_input_sel ? 8'hC3 : 8'h3C;
        end else begin
            adc_sample <= ~adc_sample;
        end
    end

    // Cuts a hung run short.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    // --------------------------------------------------------------
    // Helpers.
    // --------------------------------------------------------------

    // Write, then let the edge's updates land.
    task automatic w(input logic [3:0] a, input logic [7:0] v);
        adm_host_model_i.wr(a, v);
        @(negedge clk_sys);
    endtask

    // Counts the cycles in which the converter stays powered, starting in
    // the cycle right after the start write.
    task automatic wait_off(output int k);
        k = 0;
        while (adc_power === 1'b1 && k < 2000) begin
            @(negedge clk_sys);
            k++;
        end
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, err_total);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // Main sequence.
    // --------------------------------------------------------------

    // Drives reset, then walks through the register and converter tests.
    initial begin
        rst_b = 1'b0;
        adc_sample = 8'h00;
        err_total = 0;
        tests_run = 0;
        cycles = 0;
        fs_codes = '{2'h0, 2'h2, 2'h3};
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(negedge clk_sys);
        // Reset state of the three RF enables, the range, and the status, contrast and unmapped reads.
        `CHK(freq_correction_dac.oe, 1'b0)
        `CHK(gain_control_dac.oe, 1'b0)
        `CHK(tx_power_dac.oe, 1'b0)
        `CHK(aux_full_scale_sel, 2'h0)
        adm_host_model_i.rd(`ADM_OFS_MCU_STAT_CTRL, d);
        `CHK(d, 8'h00)
        adm_host_model_i.rd(`ADM_OFS_CONTRAST, d);
        `CHK(d, 8'h01)
        adm_host_model_i.rd(4'hF, d);
        `CHK(d, 8'h00)
        end_test("reset");

        // Codes go straight out; enables are separate and independent.
        w(`ADM_OFS_FREQ, 8'hFF);
        `CHK(freq_correction_dac.code, 8'hFF)
        `CHK(freq_correction_dac.oe, 1'b0)
        w(`ADM_OFS_GAIN, 8'h00);
        w(`ADM_OFS_TXPWR, 8'h80);
        `CHK(gain_control_dac.code, 8'h00)
        `CHK(tx_power_dac.code, 8'h80)
        adm_host_model_i.rd(`ADM_OFS_FREQ, d);
        `CHK(d, 8'hFF)
        w(`ADM_OFS_MCU_INT_CTRL, 8'h01);
        `CHK(gain_control_dac.oe, 1'b1)
        `CHK(freq_correction_dac.oe, 1'b0)
        `CHK(tx_power_dac.oe, 1'b0)
        w(`ADM_OFS_MCU_INT_CTRL, 8'h02);
        `CHK(gain_control_dac.oe, 1'b0)
        `CHK(freq_correction_dac.oe, 1'b1)
        w(`ADM_OFS_DSP_STAT_CTRL, 8'h01);
        `CHK(tx_power_dac.oe, 1'b1)
        w(`ADM_OFS_FREQ, 8'h5A);
        `CHK(freq_correction_dac.code, 8'h5A)
        end_test("aux_dacs");

        // Contrast code sits in the upper nibble; bit 0 powers it down.
        w(`ADM_OFS_CONTRAST, 8'hB0);
        `CHK(contrast_dac.code, 4'hB)
        `CHK(contrast_dac.oe, 1'b1)
        w(`ADM_OFS_CONTRAST, 8'hF1);
        `CHK(contrast_dac.oe, 1'b0)
        `CHK(contrast_dac.code, 4'hF)
        end_test("contrast");

        // Every legal range code, then the forbidden one is ignored.
        for (int i = 0; i < 3; i++) begin
            w(`ADM_OFS_MCU_STAT_CTRL, {4'h0, fs_codes[i], 2'b00});
            `CHK(aux_full_scale_sel, fs_codes[i])
        end
        w(`ADM_OFS_MCU_STAT_CTRL, 8'h04);
        `CHK(aux_full_scale_sel, 2'h3)
        end_test("range");

        // Signal-strength conversion; the written value is irrelevant.
        w(`ADM_OFS_SIG_STRENGTH, 8'hFF);
        `CHK(adc_power, 1'b1)
        `CHK(adc_input_sel, 1'b0)
        wait_off(n);
        `CHK(11'(n), `ADM_CONV_CYC)
        adm_host_model_i.rd(`ADM_OFS_MCU_STAT_CTRL, d);
        `CHK(d, 8'h0D)
        adm_host_model_i.rd(`ADM_OFS_BATTERY, d);
        `CHK(d, 8'h3C)
        adm_host_model_i.rd(`ADM_OFS_SIG_STRENGTH, d);
        `CHK(d, 8'h3C)
        adm_host_model_i.rd(`ADM_OFS_MCU_STAT_CTRL, d);
        `CHK(d, 8'h0C)
        end_test("signal_strength");

        // A battery start in mid-conversion restarts the timer.
        w(`ADM_OFS_SIG_STRENGTH, 8'h00);
        repeat (100) @(posedge clk_sys);
        adm_host_model_i.rd(`ADM_OFS_MCU_STAT_CTRL, d);
        `CHK(d, 8'h0E)
        w(`ADM_OFS_BATTERY, 8'h00);
        `CHK(adc_input_sel, 1'b1)
        wait_off(n);
        `CHK(11'(n), `ADM_CONV_CYC)
        adm_host_model_i.rd(`ADM_OFS_SIG_STRENGTH, d);
        `CHK(d, 8'hC3)
        `CHK(adc_power, 1'b0)
        end_test("battery_restart");

        wrap_up();
    end

endmodule // tb_top

`default_nettype wire
